// [host_model.sv]
// host model
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic clock_in,
  input wire logic sdo_in,
  output var logic cs_n_out = 1'b1,
  output var logic sclk_out = 1'b0,
  output var logic sdi_out = 1'b0
);
  task xfer(input logic w, input logic [5:0] a, input logic [7:0] d, input int n, output logic [7:0] q);
    logic [15:0] f;
    f = {d, ~w, a, w};
    q = 8'h00;
    cs_n_out <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      sdi_out <= f[i];
      repeat (4) @(posedge clock_in);
      sclk_out <= 1'b1;
      if (i > 7) q[i - 8] = sdo_in;
      repeat (4) @(posedge clock_in);
      sclk_out <= 1'b0;
    end
    repeat (4) @(posedge clock_in);
    cs_n_out <= 1'b1;
    sdi_out <= ~sdi_out;
    repeat (6) @(posedge clock_in);
  endtask
endmodule
`default_nettype wire

// [port_chk_checker.sv]
// port checker
`timescale 1ns/1ns
`default_nettype none
module port_chk (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic [7:0] status_in,
  input wire logic sdo_out,
  input wire logic sdo_oe_out,
  input wire logic int_n_out,
  input wire logic [7:0] reg0_out
);
  logic sclk_q;
  logic [4:0] fall_cnt;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  // serial clock falls counted per selected frame
  always @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      sclk_q <= 1'b0;
      fall_cnt <= 5'h00;
    end
    else
    begin
      sclk_q <= sclk_in;
      if (cs_n_in)
        fall_cnt <= 5'h00;
      else if (sclk_q && !sclk_in)
        fall_cnt <= fall_cnt + 5'h01;
    end
  end
  sequence oe_span; !sclk_in ##1 sdo_oe_out [*8]; endsequence
  sequence last_fall; sclk_q && !sclk_in && fall_cnt == 5'h0F; endsequence
  chk_oe_first: assert property ($rose(sdo_oe_out) |-> fall_cnt == 5'h08) else $error("late");
  chk_oe_done: assert property (last_fall |-> ##3 !sdo_oe_out) else $error("stuck");
  chk_int_idle: assert property (status_in == 8'h00 |=> int_n_out) else $error("spurious");
  chk_oe_span: assert property ($rose(sdo_oe_out) |-> oe_span) else $error("short");
  chk_sdo_fall: assert property (sdo_oe_out && $changed(sdo_out) |-> !$past(sclk_in, 2))
    else $error("moved");
  chk_oe_stop: assert property ($rose(cs_n_in) |-> ##5 !sdo_oe_out) else $error("held");
  chk_reg_cs: assert property ($changed(reg0_out) |-> $past(cs_n_in, 2)) else $error("early");
endmodule
bind serial_host_register_port port_chk u_chk (
  .clock_in(clock_in),
  .rstn_in(rstn_in),
  .cs_n_in(cs_n_in),
  .sclk_in(sclk_in),
  .status_in(status_in),
  .sdo_out(sdo_out),
  .sdo_oe_out(sdo_oe_out),
  .int_n_out(int_n_out),
  .reg0_out(reg0_out)
);
`default_nettype wire

// [serial_host_register_port.v]
// serial register access port with register storage and status interrupt
// Operation
// - one frame is exactly sixteen serial bits from the host.
// - input data is captured on each of the first sixteen serial clock rising edges while selected.
// - nothing is committed before all sixteen bits are captured.
// - read data output changes only on serial clock falling edges.
// - first bit chooses direction, zero write and one read.
// - bits two to seven carry the six bit address, bit zero first.
// - eighth bit is ignored for both directions.
// - bits nine to sixteen carry eight write data bits, bit zero first.
// - write data loads into the register when chip select rises.
// - read drives bit zero at eighth falling edge, then one bit per fall.
// - after eight read bits the output returns to high impedance.
// - reset low returns every register to its default.
// - an interrupt output lets the host watch status without polling.
`timescale 1ns/1ns
`default_nettype none
`include "serial_port_map.vh"
module serial_host_register_port #(
  parameter ADDR_WIDTH = `ADDR_WIDTH,
  parameter DATA_WIDTH = `DATA_WIDTH,
  parameter REG_COUNT = `REG_COUNT
)
(
  input wire clock_in,
  input wire rstn_in,
  input wire cs_n_in,
  input wire sclk_in,
  input wire sdi_in,
  input wire [DATA_WIDTH-1:0] status_in,
  output reg sdo_out,
  output reg sdo_oe_out,
  output reg int_n_out,
  output reg [DATA_WIDTH-1:0] reg0_out
);
  // =========================================================
  // input synchronisers
  reg cs_s1;
  reg cs_s2;
  reg cs_s3;
  reg sclk_s1;
  reg sclk_s2;
  reg sclk_s3;
  reg sdi_s1;
  reg sdi_s2;
  wire sclk_rise;
  wire sclk_fall;
  wire cs_release;
  always @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
    end
    else
    begin
      cs_s1 <= cs_n_in;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      sclk_s1 <= sclk_in;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      sdi_s1 <= sdi_in;
      sdi_s2 <= sdi_s1;
    end
  end
  assign sclk_rise = sclk_s2 & ~sclk_s3 & ~cs_s2;
  assign sclk_fall = ~sclk_s2 & sclk_s3 & ~cs_s2;
  assign cs_release = cs_s2 & ~cs_s3;

  // =========================================================
  // frame capture
  reg [4:0] bit_count;
  reg dir;
  reg [ADDR_WIDTH-1:0] addr;
  reg [DATA_WIDTH-1:0] wdata;
  reg [DATA_WIDTH-1:0] regs [0:REG_COUNT-1];
  reg [DATA_WIDTH-1:0] rdata;
  reg [3:0] out_count;
  always @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      bit_count <= 5'h00;
      dir <= `DIR_WRITE;
      addr <= {ADDR_WIDTH{1'b0}};
      wdata <= {DATA_WIDTH{1'b0}};
    end
    else if (cs_s2)
    begin
      bit_count <= 5'h00;
    end
    else if (sclk_rise && bit_count < `FRAME_BITS)
    begin
      bit_count <= bit_count + 5'h01;
      if (bit_count == `DIR_BIT)
        dir <= sdi_s2;
      else if (bit_count >= `ADDR_FIRST_BIT && bit_count < `DUMMY_BIT)
        addr <= {sdi_s2, addr[ADDR_WIDTH-1:1]};
      else if (bit_count >= `DATA_FIRST_BIT)
        wdata <= {sdi_s2, wdata[DATA_WIDTH-1:1]};
      // dummy bit falls through unused
    end
  end

  // =========================================================
  // register storage
  genvar gi;
  generate
    for (gi = 0; gi < REG_COUNT; gi = gi + 1)
    begin : g_reg
      always @(posedge clock_in or negedge rstn_in)
      begin
        if (!rstn_in)
          regs[gi] <= `REG_RESET;
        else if (cs_release && bit_count == `FRAME_BITS && dir == `DIR_WRITE
                 && addr == gi)
          regs[gi] <= wdata;
      end
    end
  endgenerate

  // =========================================================
  // read output
  localparam RD_IDLE = 2'b00;
  localparam RD_SHIFT = 2'b01;
  localparam RD_DONE = 2'b10;
  reg [1:0] rd_state;
  reg [1:0] next_rd_state;
  reg next_sdo;
  reg next_sdo_oe;
  reg [DATA_WIDTH-1:0] next_rdata;
  reg [3:0] next_out_count;
  wire read_start;
  assign read_start = sclk_fall && dir == `DIR_READ && bit_count == `DUMMY_BIT + 5'h01;
  always @*
  begin
    next_rd_state = rd_state;
    next_sdo = sdo_out;
    next_sdo_oe = sdo_oe_out;
    next_rdata = rdata;
    next_out_count = out_count;
    case (rd_state)
      RD_IDLE:
      begin
        if (read_start)
        begin
          next_sdo = regs[addr][0];
          next_rdata = regs[addr] >> 1;
          next_sdo_oe = 1'b1;
          next_out_count = 4'h1;
          next_rd_state = RD_SHIFT;
        end
      end
      RD_SHIFT:
      begin
        if (sclk_fall && out_count < `READ_BITS)
        begin
          next_sdo = rdata[0];
          next_rdata = rdata >> 1;
          next_out_count = out_count + 4'h1;
        end
        else if (sclk_fall)
        begin
          next_sdo_oe = 1'b0;
          next_rd_state = RD_DONE;
        end
      end
      RD_DONE:
      begin
        next_sdo_oe = 1'b0;
      end
      default:
      begin
        next_sdo_oe = 1'b0;
        next_rd_state = RD_IDLE;
      end
    endcase
    if (cs_s2)
    begin
      next_sdo_oe = 1'b0;
      next_out_count = 4'h0;
      next_rd_state = RD_IDLE;
    end
  end
  always @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rd_state <= RD_IDLE;
      sdo_out <= 1'b0;
      sdo_oe_out <= 1'b0;
      out_count <= 4'h0;
      rdata <= {DATA_WIDTH{1'b0}};
    end
    else
    begin
      rd_state <= next_rd_state;
      sdo_out <= next_sdo;
      sdo_oe_out <= next_sdo_oe;
      out_count <= next_out_count;
      rdata <= next_rdata;
    end
  end

  // =========================================================
  // outputs
  always @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      int_n_out <= 1'b1;
      reg0_out <= `REG_RESET;
    end
    else
    begin
      int_n_out <= ~|(status_in & regs[1]);
      reg0_out <= regs[0];
    end
  end
endmodule
`default_nettype wire

// [serial_port_map.vh]
// constants for the serial register access port
`ifndef SERIAL_PORT_MAP_VH
`define SERIAL_PORT_MAP_VH
`define FRAME_BITS 5'h10
`define DIR_BIT 5'h00
`define ADDR_FIRST_BIT 5'h01
`define DUMMY_BIT 5'h07
`define DATA_FIRST_BIT 5'h08
`define ADDR_WIDTH 6
`define DATA_WIDTH 8
`define REG_COUNT 64
`define READ_BITS 4'h8
`define REG_RESET 8'h00
`define DIR_WRITE 1'b0
`define DIR_READ 1'b1
`define RESET_MIN_NS 10
`define CLOCK_PERIOD_NS 100
`define RESET_MIN_CYCLES 1
`endif

// [test_serial_host_register_port.sv]
// port bench
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
  $display("MISMATCH %0t %h %h", $time, a, b); end end
module test_serial_host_register_port;
  logic clock_in = 1'b0, rstn_in = 1'b0;
  logic [7:0] status_in = 8'h00, rd;
  wire cs_n_in, sclk_in, sdi_in, sdo_out, sdo_oe_out, int_n_out;
  wire [7:0] reg0_out;
  int err_total = 0, num_checks = 0;
  always #50 clock_in = ~clock_in;
  serial_host_register_port u_dut (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .cs_n_in(cs_n_in),
    .sclk_in(sclk_in),
    .sdi_in(sdi_in),
    .status_in(status_in),
    .sdo_out(sdo_out),
    .sdo_oe_out(sdo_oe_out),
    .int_n_out(int_n_out),
    .reg0_out(reg0_out)
  );
  // a released data line shows the inverse of its last bit
  host_model u_host (
    .clock_in(clock_in),
    .sdo_in(sdo_oe_out ? sdo_out : ~sdo_out),
    .cs_n_out(cs_n_in),
    .sclk_out(sclk_in),
    .sdi_out(sdi_in)
  );
  task test_done;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task t_rw;
    u_host.xfer(1'b0, 6'h00, 8'hA5, 16, rd);
    u_host.xfer(1'b0, 6'h00, 8'h3C, 12, rd);
    `CHK(reg0_out, 8'hA5)
    u_host.xfer(1'b0, 6'h2A, 8'h5A, 16, rd);
    u_host.xfer(1'b1, 6'h2A, 8'h00, 16, rd);
    `CHK({sdo_oe_out, rd}, 9'h05A)
    `CHK(reg0_out, 8'hA5)
  endtask
  task t_irq;
    status_in <= 8'h02;
    u_host.xfer(1'b0, 6'h01, 8'h01, 16, rd);
    `CHK(int_n_out, 1'b1)
    u_host.xfer(1'b0, 6'h01, 8'h03, 16, rd);
    `CHK(int_n_out, 1'b0)
    status_in <= 8'h00;
    repeat (2) @(posedge clock_in);
    `CHK(int_n_out, 1'b1)
  endtask
  task t_rst;
    rstn_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    `CHK(reg0_out, 8'h00)
  endtask
  initial
  begin
    t_rst;
    t_rw;
    t_irq;
    t_rst;
    test_done;
  end
endmodule
`default_nettype wire
